// >>> logic/fawp_protect.sv
// fawp_protect: status-word write protection of a serial flash array.
// assumes framed commands arrive one per cycle on cmd_valid, already decoded
// from the serial link; power_cycle marks a power-down/power-up event, rst_n
// loads the factory values of the stored bits.
`timescale 1ns/1ns
module fawp_protect
  import fawp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_cycle,
  input wire logic wp_n,
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] cmd_code,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [STAT_W-1:0] cmd_data,
  output logic [STAT_W-1:0] status_word,
  output logic [BYTE_W-1:0] rd_data,
  output logic rd_valid,
  output logic sr_written,
  output logic sr_refused,
  output logic op_start,
  output logic op_blocked,
  output logic four_line_enable,
  output logic prot_any,
  output logic [ADDR_W-1:0] prot_lo,
  output logic [ADDR_W-1:0] prot_hi
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic region_hits(
    input logic [23:0] r_lo,
    input logic [23:0] r_hi,
    input logic [23:0] p_lo,
    input logic [23:0] p_hi,
    input logic p_any
  );
    return p_any && !((r_hi < p_lo) || (r_lo > p_hi));
  endfunction

  function automatic logic [15:0] pack_status(
    input logic wl,
    input logic [2:0] rng,
    input logic ends,
    input logic gran,
    input logic [1:0] lk,
    input logic qe,
    input logic inv,
    input logic ps
  );
    logic [15:0] w;
    w = '0;
    w[BIT_WL] = wl;
    w[BIT_BP0 +: BP_W] = rng;
    w[BIT_END] = ends;
    w[BIT_GRAN] = gran;
    w[BIT_LKL] = lk[0];
    w[BIT_LKU] = lk[1];
    w[BIT_QE] = qe;
    w[BIT_INV] = inv;
    w[BIT_PAUSE] = ps;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // stored bits and decoder

  logic [2:0] range_code;
  logic end_sel;
  logic granule;
  logic [1:0] lock_mode;
  logic quad_en;
  logic invert;
  logic paused;
  logic latch;

  fawp_prot_if pif ();

  assign pif.range_code = range_code;
  assign pif.end_sel = end_sel;
  assign pif.granule = granule;
  assign pif.invert = invert;

  fawp_range_dec u_dec (
    .pif(pif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic is_sr_write;
  logic is_mod_cmd;
  logic sr_ok;
  logic [23:0] reg_lo;
  logic [23:0] reg_hi;
  logic [15:0] wword;

  always_comb begin
    is_sr_write = cmd_valid &&
                  ((cmd_code == CMD_WRSR) || (cmd_code == CMD_WRSR2));
    is_mod_cmd = cmd_valid &&
                 ((cmd_code == CMD_PP) || (cmd_code == CMD_SE) ||
                  (cmd_code == CMD_BE32) || (cmd_code == CMD_BE64) ||
                  (cmd_code == CMD_CE) || (cmd_code == CMD_CE2));
    // lock modes 10 and 11 refuse; 01 needs the pin high
    sr_ok = latch && ((lock_mode == LOCK_SW) ||
                      ((lock_mode == LOCK_HW) && wp_n));
    reg_lo = ADDR_ZERO;
    reg_hi = ARRAY_TOP;
    unique case (cmd_code)
      CMD_PP: begin
        reg_lo = cmd_addr & ~PAGE_MASK;
        reg_hi = cmd_addr | PAGE_MASK;
      end
      CMD_SE: begin
        reg_lo = cmd_addr & ~SE_MASK;
        reg_hi = cmd_addr | SE_MASK;
      end
      CMD_BE32: begin
        reg_lo = cmd_addr & ~BE32_MASK;
        reg_hi = cmd_addr | BE32_MASK;
      end
      CMD_BE64: begin
        reg_lo = cmd_addr & ~BE64_MASK;
        reg_hi = cmd_addr | BE64_MASK;
      end
      default: begin
        reg_lo = ADDR_ZERO;
        reg_hi = ARRAY_TOP;
      end
    endcase
    // the second write form carries only the upper byte
    if (cmd_code == CMD_WRSR) begin
      wword = cmd_data;
    end else begin
      wword = {cmd_data[BYTE_W-1:0], status_word[BYTE_W-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [2:0] next_range_code;
  logic next_end_sel;
  logic next_granule;
  logic [1:0] next_lock_mode;
  logic next_quad_en;
  logic next_invert;
  logic next_paused;
  logic next_latch;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic next_sr_written;
  logic next_sr_refused;
  logic next_op_start;
  logic next_op_blocked;

  always_comb begin
    next_range_code = range_code;
    next_end_sel = end_sel;
    next_granule = granule;
    next_lock_mode = lock_mode;
    next_quad_en = quad_en;
    next_invert = invert;
    next_paused = paused;
    next_latch = latch;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_sr_written = 1'b0;
    next_sr_refused = 1'b0;
    next_op_start = 1'b0;
    next_op_blocked = 1'b0;
    // power cycle first, so a command in the same cycle wins
    if (power_cycle) begin
      next_latch = 1'b0;
      next_paused = 1'b0;
      if (lock_mode == LOCK_PWR) begin
        next_lock_mode = LOCK_SW;
      end
    end
    if (cmd_valid) begin
      if (cmd_code == CMD_WREN) begin
        next_latch = 1'b1;
      end else if (cmd_code == CMD_WRDI) begin
        next_latch = 1'b0;
      end else if (is_sr_write) begin
        next_latch = 1'b0;
        if (sr_ok) begin
          next_range_code = wword[BIT_BP0 +: BP_W];
          next_end_sel = wword[BIT_END];
          next_granule = wword[BIT_GRAN];
          next_lock_mode = {wword[BIT_LKU], wword[BIT_LKL]};
          next_quad_en = wword[BIT_QE];
          next_invert = wword[BIT_INV];
          next_sr_written = 1'b1;
        end else begin
          next_sr_refused = 1'b1;
        end
      end else if (is_mod_cmd) begin
        next_latch = 1'b0;
        if (latch && !region_hits(reg_lo, reg_hi, pif.lo, pif.hi, pif.any)) begin
          next_op_start = 1'b1;
        end else begin
          next_op_blocked = 1'b1;
        end
      end else if (cmd_code == CMD_SUSP) begin
        next_paused = 1'b1;
      end else if (cmd_code == CMD_RESUME) begin
        next_paused = 1'b0;
      end else if (cmd_code == CMD_RDSR) begin
        next_rd_data = status_word[BYTE_W-1:0];
        next_rd_valid = 1'b1;
      end else if (cmd_code == CMD_RDSR2) begin
        next_rd_data = status_word[STAT_W-1:BYTE_W];
        next_rd_valid = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      range_code <= DEF_RANGE;
      end_sel <= DEF_END;
      granule <= DEF_GRAN;
      lock_mode <= DEF_LOCK;
      quad_en <= DEF_QE;
      invert <= DEF_INV;
      paused <= 1'b0;
      latch <= 1'b0;
      status_word <= pack_status(1'b0, DEF_RANGE, DEF_END, DEF_GRAN,
                                 DEF_LOCK, DEF_QE, DEF_INV, 1'b0);
      four_line_enable <= DEF_QE;
      rd_data <= '0;
      rd_valid <= 1'b0;
      sr_written <= 1'b0;
      sr_refused <= 1'b0;
      op_start <= 1'b0;
      op_blocked <= 1'b0;
      prot_any <= 1'b0;
      prot_lo <= '0;
      prot_hi <= '0;
    end else begin
      range_code <= next_range_code;
      end_sel <= next_end_sel;
      granule <= next_granule;
      lock_mode <= next_lock_mode;
      quad_en <= next_quad_en;
      invert <= next_invert;
      paused <= next_paused;
      latch <= next_latch;
      status_word <= pack_status(next_latch, next_range_code, next_end_sel,
                                 next_granule, next_lock_mode, next_quad_en,
                                 next_invert, next_paused);
      four_line_enable <= next_quad_en;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      sr_written <= next_sr_written;
      sr_refused <= next_sr_refused;
      op_start <= next_op_start;
      op_blocked <= next_op_blocked;
      prot_any <= pif.any;
      prot_lo <= pif.lo;
      prot_hi <= pif.hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_sr_req;
    is_sr_write;
  endsequence

  sequence s_full_write;
    cmd_valid && (cmd_code == CMD_WRSR) && sr_ok;
  endsequence

  property p_range_store;
    s_full_write |=> status_word[BIT_BP0 +: BP_W] == $past(cmd_data[4:2]);
  endproperty
  a_range_store: assert property (p_range_store)
    else $error("range bits not stored by status write");

  property p_start_clean;
    $rose(rst_n) |-> (status_word[BIT_BP0 +: BP_W] == 3'h0) && !prot_any;
  endproperty
  a_start_clean: assert property (p_start_clean)
    else $error("array protected out of reset");

  property p_blocked;
    is_mod_cmd && region_hits(reg_lo, reg_hi, pif.lo, pif.hi, pif.any)
      |=> op_blocked && !op_start;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("program or erase started on protected region");

  property p_sw_mode;
    (s_sr_req and ((lock_mode == LOCK_SW) && latch))
      |=> sr_written ##1 !sr_written;
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("status write refused in software mode");

  property p_hw_lock;
    (s_sr_req and ((lock_mode == LOCK_HW) && !wp_n))
      |=> sr_refused && $stable(status_word[BIT_INV:BIT_BP0]);
  endproperty
  a_hw_lock: assert property (p_hw_lock)
    else $error("status write taken with protect pin low");

  property p_hw_open;
    (s_sr_req and ((lock_mode == LOCK_HW) && wp_n && latch))
      |=> sr_written;
  endproperty
  a_hw_open: assert property (p_hw_open)
    else $error("status write refused with protect pin high");

  property p_pwr_lock;
    (s_sr_req and ((lock_mode == LOCK_PWR) && !power_cycle))
      |=> sr_refused && (status_word[BIT_LKU] && !status_word[BIT_LKL]);
  endproperty
  a_pwr_lock: assert property (p_pwr_lock)
    else $error("status write taken under power lock");

  property p_pwr_release;
    power_cycle && (lock_mode == LOCK_PWR) && !is_sr_write
      |=> !status_word[BIT_LKU] && !status_word[BIT_LKL];
  endproperty
  a_pwr_release: assert property (p_pwr_release)
    else $error("power cycle did not release lock");

  property p_otp;
    (lock_mode == LOCK_OTP) |=> (lock_mode == LOCK_OTP) &&
      $stable(range_code) && $stable(invert);
  endproperty
  a_otp: assert property (p_otp)
    else $error("permanent lock changed");

  property p_quad;
    four_line_enable == status_word[BIT_QE];
  endproperty
  a_quad: assert property (p_quad)
    else $error("four-line enable disagrees with status");

  property p_pause;
    cmd_valid && (cmd_code == CMD_SUSP) |=> status_word[BIT_PAUSE] [*1]
      ##1 (status_word[BIT_PAUSE] || $past(power_cycle || cmd_valid));
  endproperty
  a_pause: assert property (p_pause)
    else $error("paused flag not held after suspend");

  property p_top_half;
    (range_code == 3'h6) && !end_sel && !granule && !invert
      |-> pif.any && (pif.lo == 24'h800000) && (pif.hi == 24'hffffff);
  endproperty
  a_top_half: assert property (p_top_half)
    else $error("top half range wrong");

  property p_bot_sixty4;
    (range_code == 3'h1) && end_sel && !granule && !invert
      |-> (pif.lo == 24'h000000) && (pif.hi == 24'h03ffff);
  endproperty
  a_bot_sixty4: assert property (p_bot_sixty4)
    else $error("bottom 1/64 range wrong");

  property p_sec_top;
    (range_code == 3'h5) && !end_sel && granule && !invert
      |-> pif.lo == 24'hff8000;
  endproperty
  a_sec_top: assert property (p_sec_top)
    else $error("top sector range wrong");

  property p_sec_bot;
    (range_code == 3'h1) && end_sel && granule && !invert
      |-> pif.hi == 24'h000fff;
  endproperty
  a_sec_bot: assert property (p_sec_bot)
    else $error("bottom sector range wrong");

  property p_latch;
    cmd_valid && (cmd_code == CMD_WREN) |=> status_word[BIT_WL];
  endproperty
  a_latch: assert property (p_latch)
    else $error("write latch not set by write enable");

endmodule

// >>> logic/fawp_pkg.sv
// fawp_pkg: constants shared by the flash write-protection block.
// assumes a 16-mbyte array with 24-bit byte addresses.
package fawp_pkg;

  localparam int ADDR_W = 24;
  localparam int STAT_W = 16;
  localparam int CMD_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // status word bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_WL = 1;
  localparam int BIT_BP0 = 2;
  localparam int BP_W = 3;
  localparam int BIT_END = 5;
  localparam int BIT_GRAN = 6;
  localparam int BIT_LKL = 7;
  localparam int BIT_LKU = 8;
  localparam int BIT_QE = 9;
  localparam int BIT_INV = 14;
  localparam int BIT_PAUSE = 15;
  localparam int BYTE_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // factory defaults of the stored bits
  localparam logic [2:0] DEF_RANGE = 3'h0;
  localparam logic DEF_END = 1'b0;
  localparam logic DEF_GRAN = 1'b0;
  localparam logic [1:0] DEF_LOCK = 2'h0;
  localparam logic DEF_QE = 1'b1;
  localparam logic DEF_INV = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // lock modes {upper, lower}
  localparam logic [1:0] LOCK_SW = 2'h0;
  localparam logic [1:0] LOCK_HW = 2'h1;
  localparam logic [1:0] LOCK_PWR = 2'h2;
  localparam logic [1:0] LOCK_OTP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // range decode
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ONE = 3'h1;
  localparam logic [2:0] BP_SEC_CAP = 3'h4;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [23:0] ADDR_ZERO = 24'h000000;
  localparam logic [23:0] ADDR_ONE = 24'h000001;
  localparam logic [23:0] ARRAY_TOP = 24'hffffff;
  localparam logic [23:0] BLK_UNIT = 24'h040000;
  localparam logic [23:0] SEC_UNIT = 24'h001000;
  localparam logic [23:0] SEC_MAX = 24'h008000;

  ////////////////////////////////////////////////////////////////////////////
  // region masks of program and erase commands
  localparam logic [23:0] PAGE_MASK = 24'h0000ff;
  localparam logic [23:0] SE_MASK = 24'h000fff;
  localparam logic [23:0] BE32_MASK = 24'h007fff;
  localparam logic [23:0] BE64_MASK = 24'h00ffff;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_RDSR2 = 8'h35;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_WRSR2 = 8'h31;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_BE32 = 8'h52;
  localparam logic [7:0] CMD_BE64 = 8'hd8;
  localparam logic [7:0] CMD_CE = 8'h60;
  localparam logic [7:0] CMD_CE2 = 8'hc7;
  localparam logic [7:0] CMD_SUSP = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7a;

endpackage

// >>> logic/fawp_prot_if.sv
// fawp_prot_if: stored protection bits out, decoded protected range back.
// assumes one producer of the bits and one combinational decoder.
`timescale 1ns/1ns
interface fawp_prot_if;
  logic [2:0] range_code;
  logic end_sel;
  logic granule;
  logic invert;
  logic [23:0] lo;
  logic [23:0] hi;
  logic any;

  modport src (
    output range_code,
    output end_sel,
    output granule,
    output invert,
    input lo,
    input hi,
    input any
  );

  modport dec (
    input range_code,
    input end_sel,
    input granule,
    input invert,
    output lo,
    output hi,
    output any
  );
endinterface

// >>> logic/fawp_range_dec.sv
// fawp_range_dec: turns protection bits into one protected address range.
// assumes ranges anchored at an array end, so the complement stays one range.
`timescale 1ns/1ns
module fawp_range_dec
  import fawp_pkg::*;
(
  fawp_prot_if.dec pif
);

  logic [23:0] size;
  logic [23:0] base_lo;
  logic [23:0] base_hi;
  logic base_any;

  always_comb begin
    // sector units cap at 32 kbytes, block units double from 1/64
    if (pif.granule) begin
      if (pif.range_code >= BP_SEC_CAP) begin
        size = SEC_MAX;
      end else begin
        size = 24'(SEC_UNIT << (pif.range_code - BP_ONE));
      end
    end else begin
      size = 24'(BLK_UNIT << (pif.range_code - BP_ONE));
    end
    base_any = (pif.range_code != BP_NONE);
    if (pif.range_code == BP_ALL) begin
      base_lo = ADDR_ZERO;
      base_hi = ARRAY_TOP;
    end else if (pif.end_sel) begin
      base_lo = ADDR_ZERO;
      base_hi = 24'(size - ADDR_ONE);
    end else begin
      base_lo = 24'(~size + ADDR_ONE);
      base_hi = ARRAY_TOP;
    end
    // swap protected and open regions
    if (!pif.invert) begin
      pif.any = base_any;
      pif.lo = base_lo;
      pif.hi = base_hi;
    end else if (!base_any) begin
      pif.any = 1'b1;
      pif.lo = ADDR_ZERO;
      pif.hi = ARRAY_TOP;
    end else if (pif.range_code == BP_ALL) begin
      pif.any = 1'b0;
      pif.lo = ADDR_ZERO;
      pif.hi = ADDR_ZERO;
    end else if (pif.end_sel) begin
      pif.any = 1'b1;
      pif.lo = 24'(base_hi + ADDR_ONE);
      pif.hi = ARRAY_TOP;
    end else begin
      pif.any = 1'b1;
      pif.lo = ADDR_ZERO;
      pif.hi = 24'(base_lo - ADDR_ONE);
    end
  end

endmodule

// >>> verification/fawp_host.sv
// fawp_host: behavioural command source standing in for the host side.
// assumes the device takes one command per rising edge with cmd_valid.
`timescale 1ns/1ns
module fawp_host
  import fawp_pkg::*;
(
  input wire logic clk_sys,
  output logic power_cycle,
  output logic wp_n,
  output logic cmd_valid,
  output logic [CMD_W-1:0] cmd_code,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [STAT_W-1:0] cmd_data
);
  initial begin
    power_cycle = 1'b0;
    wp_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = 8'hff;
    cmd_addr = 24'h000000;
    cmd_data = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one command held over exactly one rising edge
  task automatic send(input logic [7:0] c, input logic [23:0] a,
                      input logic [15:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    // released lines show a changed pattern, not the last value
    cmd_code = ~c;
    cmd_addr = ~a;
    cmd_data = ~d;
  endtask

  task automatic power();
    @(negedge clk_sys);
    power_cycle = 1'b1;
    @(negedge clk_sys);
    power_cycle = 1'b0;
  endtask

  task automatic pin(input logic v);
    @(negedge clk_sys);
    wp_n = v;
  endtask
endmodule

// >>> verification/flash_array_write_protection_tb.sv
// flash_array_write_protection_tb: command sequences with expected values.
// assumes fawp_protect and the fawp_host model are compiled before it.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module flash_array_write_protection_tb
  import fawp_pkg::*;
;
  logic clk_sys, rst_n, power_cycle, wp_n, cmd_valid;
  logic [7:0] cmd_code, rd_data;
  logic [23:0] cmd_addr, prot_lo, prot_hi;
  logic [15:0] cmd_data, status_word;
  logic rd_valid, sr_written, sr_refused, op_start, op_blocked;
  logic four_line_enable, prot_any;
  int err_count = 0;
  int checked = 0;
  // status word, any, lo, hi
  logic [64:0] tbl [15] = '{
    {16'h0004, 1'b1, 24'hfc0000, 24'hffffff},
    {16'h0018, 1'b1, 24'h800000, 24'hffffff},
    {16'h0024, 1'b1, 24'h000000, 24'h03ffff},
    {16'h0038, 1'b1, 24'h000000, 24'h7fffff},
    {16'h001c, 1'b1, 24'h000000, 24'hffffff},
    {16'h007c, 1'b1, 24'h000000, 24'hffffff},
    {16'h0044, 1'b1, 24'hfff000, 24'hffffff},
    {16'h004c, 1'b1, 24'hffc000, 24'hffffff},
    {16'h0050, 1'b1, 24'hff8000, 24'hffffff},
    {16'h0054, 1'b1, 24'hff8000, 24'hffffff},
    {16'h0064, 1'b1, 24'h000000, 24'h000fff},
    {16'h0070, 1'b1, 24'h000000, 24'h007fff},
    {16'h4004, 1'b1, 24'h000000, 24'hfbffff},
    {16'h0260, 1'b0, 24'h000000, 24'h000000},
    {16'h0004, 1'b1, 24'hfc0000, 24'hffffff}};

  fawp_host host (.clk_sys(clk_sys), .power_cycle(power_cycle),
    .wp_n(wp_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data));

  fawp_protect DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .power_cycle(power_cycle), .wp_n(wp_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .status_word(status_word), .rd_data(rd_data), .rd_valid(rd_valid),
    .sr_written(sr_written), .sr_refused(sr_refused),
    .op_start(op_start), .op_blocked(op_blocked),
    .four_line_enable(four_line_enable), .prot_any(prot_any),
    .prot_lo(prot_lo), .prot_hi(prot_hi));

  always #4 clk_sys = ~clk_sys;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // status write after write enable; ok says accepted or refused
  task automatic wrsr(input logic [15:0] d, input logic ok);
    host.send(CMD_WREN, 24'h0, 16'h0);
    host.send(CMD_WRSR, 24'h0, d);
    `CHK(sr_written, ok)
    `CHK(sr_refused, ~ok)
  endtask

  task automatic op(input logic [7:0] c, input logic [23:0] a,
                    input logic ok);
    host.send(CMD_WREN, 24'h0, 16'h0);
    host.send(c, a, 16'h0);
    `CHK({op_start, op_blocked, status_word[BIT_WL]}, {ok, ~ok, 1'b0})
  endtask

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    `CHK(status_word, 16'h0200)
    `CHK({four_line_enable, prot_any}, 2'h2)
    host.send(CMD_WRSR, 24'h0, 16'h001c);
    `CHK({sr_refused, status_word[4:2]}, 4'h8)
    foreach (tbl[i]) begin
      wrsr(tbl[i][64:49], 1'b1);
      @(negedge clk_sys);
      `CHK(status_word, {tbl[i][64:51], 2'h0})
      `CHK(four_line_enable, tbl[i][58])
      `CHK(prot_any, tbl[i][48])
      if (tbl[i][48])
        `CHK({prot_lo, prot_hi}, tbl[i][47:0])
    end
    op(CMD_SE, 24'hfc1234, 1'b0);
    op(CMD_SE, 24'hfbf000, 1'b1);
    op(CMD_BE64, 24'hfb0000, 1'b1);
    op(CMD_BE32, 24'hfb8000, 1'b1);
    op(CMD_PP, 24'hfbffff, 1'b1);
    op(CMD_BE64, 24'hfc0000, 1'b0);
    op(CMD_CE, 24'h0, 1'b0);
    op(CMD_CE2, 24'h0, 1'b0);
    host.send(CMD_PP, 24'h000000, 16'h0);
    `CHK(op_blocked, 1'b1)
    host.send(CMD_WREN, 24'h0, 16'h0);
    `CHK(status_word[BIT_WL], 1'b1)
    host.send(CMD_WRDI, 24'h0, 16'h0);
    `CHK(status_word[BIT_WL], 1'b0)
    wrsr(16'h0080, 1'b1);
    host.pin(1'b0);
    wrsr(16'h0000, 1'b0);
    `CHK(status_word[8:7], 2'h1)
    host.pin(1'b1);
    wrsr(16'h00a0, 1'b1);
    `CHK(status_word[BIT_END], 1'b1)
    wrsr(16'h0100, 1'b1);
    wrsr(16'h0000, 1'b0);
    host.power();
    `CHK(status_word, 16'h0000)
    host.pin(1'b0);
    host.send(CMD_WREN, 24'h0, 16'h0);
    host.send(CMD_WRSR2, 24'h0, 16'h0042);
    `CHK({sr_written, status_word}, 17'h14200)
    `CHK(four_line_enable, 1'b1)
    host.pin(1'b1);
    host.send(CMD_SUSP, 24'h0, 16'h0);
    `CHK(status_word[BIT_PAUSE], 1'b1)
    host.send(CMD_RESUME, 24'h0, 16'h0);
    `CHK(status_word[BIT_PAUSE], 1'b0)
    host.send(CMD_SUSP, 24'h0, 16'h0);
    host.power();
    `CHK(status_word[BIT_PAUSE], 1'b0)
    wrsr(16'h0180, 1'b1);
    wrsr(16'h0000, 1'b0);
    host.power();
    wrsr(16'h0000, 1'b0);
    host.send(CMD_RDSR, 24'h0, 16'h0);
    `CHK({rd_valid, rd_data}, 9'h180)
    host.send(CMD_RDSR2, 24'h0, 16'h0);
    `CHK({rd_valid, rd_data}, 9'h101)
    complete_run();
  end
endmodule
